// ===== logic/cfgia_pkg.sv
// Constants for the configuration index/data access unit.
// Assumes a byte-wide host I/O bus with strobes synchronous to sys_clk.
package cfgia_pkg;

  // ----------------------------------------------------------------
  // widths and register file shape
  // ----------------------------------------------------------------
  localparam int CFGIA_DATA_W   = 8;
  localparam int CFGIA_ADDR_W   = 16;
  localparam int CFGIA_NUM_REGS = 15;
  localparam int CFGIA_SEL_W    = 4;
  localparam int CFGIA_STRAP_W  = 5;
  localparam int CFGIA_LOC_W    = 2;

  // indexes of the strap-loaded registers and of the last register
  localparam logic [3:0] CFGIA_IDX_FUNC_ENABLE  = 4'h0;
  localparam logic [3:0] CFGIA_IDX_FUNC_ADDRESS = 4'h1;
  localparam logic [3:0] CFGIA_IDX_POWER_TEST   = 4'h2;
  localparam logic [3:0] CFGIA_IDX_LAST         = 4'he;

  // index port field layout; bits 4..6 are reserved and read zero
  localparam logic [7:0] CFGIA_INDEX_KEEP_MASK = 8'h8f;
  localparam logic [7:0] CFGIA_RESET_VALUE     = 8'h00;
  localparam logic [7:0] CFGIA_SECOND_READ     = 8'h00;
  localparam logic [7:0] CFGIA_UNMAPPED_READ   = 8'h00;

  // identification byte: value is arbitrary
  localparam logic [7:0] CFGIA_ID_BYTE = 8'h5a;

  // port pair locations, selected by the location straps
  localparam logic [15:0] CFGIA_INDEX_ADDR [0:3] = '{16'h0398, 16'h026e, 16'h015c, 16'h002e};

  // ----------------------------------------------------------------
  // strap default sets
  // ----------------------------------------------------------------
  localparam logic [7:0] CFGIA_FER_BASE [0:31] = '{
    8'h4f, 8'h4f, 8'h4f, 8'h4f, 8'h4f, 8'h4f,
    8'h4b, 8'h4b, 8'h4b, 8'h4b, 8'h4b, 8'h4b,
    8'h0f, 8'h0f, 8'h0f, 8'h0f,
    8'h49, 8'h49, 8'h49, 8'h49,
    8'h07, 8'h07, 8'h07, 8'h07,
    8'h47, 8'h47, 8'h47, 8'h47, 8'h47, 8'h47,
    8'h08, 8'h00};
  localparam logic [7:0] CFGIA_FAR_TABLE [0:31] = '{
    8'h10, 8'h11, 8'h11, 8'h39, 8'h24, 8'h38,
    8'h00, 8'h01, 8'h01, 8'h09, 8'h08, 8'h08,
    8'h10, 8'h11, 8'h39, 8'h24,
    8'h00, 8'h01, 8'h01, 8'h00,
    8'h10, 8'h11, 8'h39, 8'h24,
    8'h10, 8'h11, 8'h11, 8'h39, 8'h24, 8'h38,
    8'h10, 8'h10};
  // codes whose IDE function sits at the secondary address
  localparam logic [31:0] CFGIA_IDE_SEC_MASK   = 32'h240c0924;
  localparam logic [7:0]  CFGIA_FER_IDE_SEC    = 8'h80;
  localparam logic [7:0]  CFGIA_PTR_ACTIVE     = 8'h00;
  localparam logic [7:0]  CFGIA_PTR_ALL_OFF    = 8'h02;
  localparam logic [7:0]  CFGIA_PTR_OPTION_BIT = 8'h80;
  localparam int          CFGIA_PTR_XTAL_BIT   = 1;

  // index read sequence after reset; gray along id -> zero -> echo
  typedef enum logic [1:0] {
    CFGIA_RD_ID   = 2'b00,
    CFGIA_RD_ZERO = 2'b01,
    CFGIA_RD_ECHO = 2'b11
  } cfgia_rdseq_e;

endpackage : cfgia_pkg

// ===== logic/cfgia_strap_defaults.sv
// Strap decoder: turns the five default straps into three reset values.
// Assumes the strap code is held stable while it is being loaded.
module cfgia_strap_defaults #(
  parameter logic PTR_OPTION = 1'b0
) (
  // strap code
  input  wire logic [cfgia_pkg::CFGIA_STRAP_W-1:0] strapCode,
  // default values
  output logic      [cfgia_pkg::CFGIA_DATA_W-1:0]  ferDefault,
  output logic      [cfgia_pkg::CFGIA_DATA_W-1:0]  farDefault,
  output logic      [cfgia_pkg::CFGIA_DATA_W-1:0]  ptrDefault
);
  import cfgia_pkg::*;

  // ----------------------------------------------------------------
  // table lookup
  // ----------------------------------------------------------------
  wire logic [7:0] ferBase  = CFGIA_FER_BASE[strapCode];
  wire logic       ideSec   = CFGIA_IDE_SEC_MASK[strapCode];
  wire logic       noneOn   = (ferBase == CFGIA_RESET_VALUE);
  wire logic [7:0] ptrOpt   = PTR_OPTION ? CFGIA_PTR_OPTION_BIT : CFGIA_RESET_VALUE;

  // ide select bit is the only difference between the two enable choices
  assign ferDefault = ferBase | (ideSec ? CFGIA_FER_IDE_SEC : CFGIA_RESET_VALUE);
  // only the listed serial and parallel encodings appear in the table
  assign farDefault = CFGIA_FAR_TABLE[strapCode];
  // all-off code also allows the crystal to stop
  assign ptrDefault = (noneOn ? CFGIA_PTR_ALL_OFF : CFGIA_PTR_ACTIVE) | ptrOpt;

endmodule // cfgia_strap_defaults

// ===== logic/cfgia_config_access.sv
// Configuration index/data access unit: index port, data port,
// fifteen byte registers and strap defaults loaded after reset.
// Assumes host strobes and address are synchronous to sys_clk and each
// strobe is held low for at least two clock cycles.
module cfgia_config_access #(
  parameter logic PTR_OPTION = 1'b0
) (
  // clock, reset, enable
  input  wire logic                                    sys_clk,
  input  wire logic                                    reset,
  input  wire logic                                    clkEn,
  // host i/o bus
  input  wire logic [cfgia_pkg::CFGIA_ADDR_W-1:0]      ioAddr,
  input  wire logic                                    ioRdN,
  input  wire logic                                    ioWrN,
  input  wire logic [cfgia_pkg::CFGIA_DATA_W-1:0]      ioDataIn,
  output logic      [cfgia_pkg::CFGIA_DATA_W-1:0]      ioDataOut,
  output logic                                         ioDataOe,
  // straps
  input  wire logic [cfgia_pkg::CFGIA_STRAP_W-1:0]     defaultSelectStraps,
  input  wire logic [cfgia_pkg::CFGIA_LOC_W-1:0]       portLocationStraps,
  // power-down
  input  wire logic                                    powerDownInputN,
  output logic                                         clocksStop,
  output logic                                         oscStop,
  // register contents
  output logic      [cfgia_pkg::CFGIA_DATA_W-1:0]      functionEnableReg,
  output logic      [cfgia_pkg::CFGIA_DATA_W-1:0]      functionAddressReg,
  output logic      [cfgia_pkg::CFGIA_DATA_W-1:0]      powerTestReg,
  output logic      [cfgia_pkg::CFGIA_NUM_REGS*8-1:0]  cfgRegsFlat
);
  import cfgia_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // all state below is frozen while clkEn is low; only the asynchronous
  // reset acts regardless of the enable
  logic         loadPending_ff;
  logic [1:0]   location_ff;
  logic         rdPrev_ff;
  logic         wrPrev_ff;
  logic [7:0]   index_ff;
  logic [7:0]   nxt_index;
  logic         firstWrite_ff;
  logic         nxt_firstWrite;
  logic [7:0]   rdData_ff;
  logic [7:0]   nxt_rdData;
  logic         clocksStop_ff;
  logic         oscStop_ff;
  cfgia_rdseq_e rdSeq_ff;
  cfgia_rdseq_e nxt_rdSeq;
  logic [7:0]   cfgRegs_ff [0:CFGIA_NUM_REGS-1];

  // ----------------------------------------------------------------
  // strap defaults
  // ----------------------------------------------------------------
  logic [7:0] ferDefault;
  logic [7:0] farDefault;
  logic [7:0] ptrDefault;

  cfgia_strap_defaults #(
    .PTR_OPTION (PTR_OPTION)
  ) u_strap_defaults (
    .strapCode  (defaultSelectStraps),
    .ferDefault (ferDefault),
    .farDefault (farDefault),
    .ptrDefault (ptrDefault)
  );

  // straps are caught on the first enabled edge after reset release,
  // never under the asynchronous reset itself
  // the location straps are caught at the same edge as the default sets,
  // so the port pair cannot move under a host that is already probing it;
  // until then every strobe is ignored and the bus is never driven
  wire logic loadNow = loadPending_ff & clkEn;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      loadPending_ff <= 1'b1;
      location_ff    <= 2'b00;
    end else if (loadNow) begin
      loadPending_ff <= 1'b0;
      location_ff    <= portLocationStraps;
    end
  end

  // ----------------------------------------------------------------
  // address decode and access detection
  // ----------------------------------------------------------------
  // the pair occupies two adjacent addresses: index, then data
  // the full sixteen-bit address is compared; a partial decode would alias
  // the pair onto the ranges of other adapters
  wire logic [15:0] indexAddr = CFGIA_INDEX_ADDR[location_ff];
  wire logic [15:0] dataAddr  = indexAddr + 16'h0001;
  wire logic        hitIndex  = (ioAddr == indexAddr);
  wire logic        hitData   = (ioAddr == dataAddr);
  wire logic        hitAny    = hitIndex | hitData;

  // a strobe counts once, on its leading edge
  // a strobe that is already low when the straps load is ignored until it
  // rises again, since the edge history keeps running during the load wait
  wire logic rdActive = ~ioRdN;
  wire logic wrActive = ~ioWrN;
  wire logic rdStart  = rdActive & ~rdPrev_ff & ~loadPending_ff;
  wire logic wrStart  = wrActive & ~wrPrev_ff & ~loadPending_ff;

  wire logic idxRead   = rdStart & hitIndex;
  wire logic idxWrite  = wrStart & hitIndex;
  wire logic dataRead  = rdStart & hitData;
  wire logic dataWrite = wrStart & hitData;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdPrev_ff <= 1'b0;
      wrPrev_ff <= 1'b0;
    end else if (clkEn) begin
      rdPrev_ff <= rdActive;
      wrPrev_ff <= wrActive;
    end
  end

  // ----------------------------------------------------------------
  // register selection
  // ----------------------------------------------------------------
  // bit 7 of the index takes no part in selection; beyond 0eh nothing maps
  // entry 0fh does not exist: reads there give zero and the commit is
  // blocked, so a stray index cannot corrupt a neighbouring register
  wire logic [3:0] selIdx   = index_ff[CFGIA_SEL_W-1:0];
  wire logic       selValid = (selIdx <= CFGIA_IDX_LAST);
  wire logic [7:0] selValue = selValid ? cfgRegs_ff[selIdx] : CFGIA_UNMAPPED_READ;

  // ----------------------------------------------------------------
  // index port
  // ----------------------------------------------------------------
  // reserved bits are dropped on the write so they can never read back
  // bit 7 is kept so a read echoes it, though it selects nothing
  always_comb begin
    nxt_index = index_ff;
    if (idxWrite) begin
      nxt_index = ioDataIn & CFGIA_INDEX_KEEP_MASK;
    end
  end

  // id byte, then 00h, then the index itself; a write skips straight to echo
  // the sequence only moves forward; once in echo it stays there until the
  // next reset, so software probing twice after a write sees its own byte
  // both times
  always_comb begin
    nxt_rdSeq = rdSeq_ff;
    unique case (rdSeq_ff)
      CFGIA_RD_ID: begin
        if (idxWrite) begin
          nxt_rdSeq = CFGIA_RD_ECHO;
        end else if (idxRead) begin
          nxt_rdSeq = CFGIA_RD_ZERO;
        end
      end
      CFGIA_RD_ZERO: begin
        if (idxWrite || idxRead) begin
          nxt_rdSeq = CFGIA_RD_ECHO;
        end
      end
      CFGIA_RD_ECHO: begin
        nxt_rdSeq = CFGIA_RD_ECHO;
      end
      default: begin
        nxt_rdSeq = CFGIA_RD_ECHO;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      index_ff <= CFGIA_RESET_VALUE;
      rdSeq_ff <= CFGIA_RD_ID;
    end else if (clkEn) begin
      index_ff <= nxt_index;
      rdSeq_ff <= nxt_rdSeq;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // read data is captured on the strobe's leading edge and held, so the
  // driven byte stays steady even if a register changes mid-cycle
  // the unused fourth sequence code reads like echo, the safe fallback
  always_comb begin
    nxt_rdData = rdData_ff;
    if (idxRead) begin
      unique case (rdSeq_ff)
        CFGIA_RD_ID:   nxt_rdData = CFGIA_ID_BYTE;
        CFGIA_RD_ZERO: nxt_rdData = CFGIA_SECOND_READ;
        CFGIA_RD_ECHO: nxt_rdData = index_ff & CFGIA_INDEX_KEEP_MASK;
        default:       nxt_rdData = index_ff & CFGIA_INDEX_KEEP_MASK;
      endcase
    end else if (dataRead) begin
      nxt_rdData = selValue;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdData_ff <= CFGIA_RESET_VALUE;
    end else if (clkEn) begin
      rdData_ff <= nxt_rdData;
    end
  end

  // the bus is driven only while a read strobe sits on one of our two ports
  // the drive starts one cycle into the strobe, once the held byte is valid;
  // a read of a foreign address leaves the held byte untouched
  assign ioDataOut = rdData_ff;
  assign ioDataOe  = rdActive & rdPrev_ff & hitAny & ~loadPending_ff;

  // ----------------------------------------------------------------
  // double write guard
  // ----------------------------------------------------------------
  // a stray data write from another driver arms the guard but cannot commit
  // trade-off: any strobe edge disarms, even one for another device, so an
  // interrupt routine touching the bus between the two writes costs a retry
  // but can never commit half of a sequence
  always_comb begin
    nxt_firstWrite = firstWrite_ff;
    if (dataWrite) begin
      nxt_firstWrite = ~firstWrite_ff;
    end else if (rdStart || wrStart) begin
      nxt_firstWrite = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      firstWrite_ff <= 1'b0;
    end else if (clkEn) begin
      firstWrite_ff <= nxt_firstWrite;
    end
  end

  // commit only on the second back-to-back data write
  wire logic commit = dataWrite & firstWrite_ff & selValid;

  // ----------------------------------------------------------------
  // configuration register file
  // ----------------------------------------------------------------
  // entries 0..2 take strap defaults once; the rest stay at zero until
  // software writes them; every entry is writable after the load
  // the strap load and a commit never meet: strobes are ignored until the
  // load edge has passed
  genvar gi;
  generate
    for (gi = 0; gi < CFGIA_NUM_REGS; gi++) begin : g_reg
      logic [7:0] strapVal;
      logic       strapped;
      logic       hitEntry;

      assign strapped = (gi == int'(CFGIA_IDX_FUNC_ENABLE)) ||
                        (gi == int'(CFGIA_IDX_FUNC_ADDRESS)) ||
                        (gi == int'(CFGIA_IDX_POWER_TEST));
      assign strapVal = (gi == int'(CFGIA_IDX_FUNC_ENABLE))  ? ferDefault :
                        (gi == int'(CFGIA_IDX_FUNC_ADDRESS)) ? farDefault : ptrDefault;
      assign hitEntry = commit && (selIdx == 4'(gi));

      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          cfgRegs_ff[gi] <= CFGIA_RESET_VALUE;
        end else if (loadNow && strapped) begin
          cfgRegs_ff[gi] <= strapVal;
        end else if (clkEn && hitEntry) begin
          cfgRegs_ff[gi] <= ioDataIn;
        end
      end

      assign cfgRegsFlat[gi*8 +: 8] = cfgRegs_ff[gi];
    end
  endgenerate

  // the three strap-loaded entries are also brought out whole for the
  // function blocks that decode them
  assign functionEnableReg  = cfgRegs_ff[CFGIA_IDX_FUNC_ENABLE];
  assign functionAddressReg = cfgRegs_ff[CFGIA_IDX_FUNC_ADDRESS];
  assign powerTestReg       = cfgRegs_ff[CFGIA_IDX_POWER_TEST];

  // ----------------------------------------------------------------
  // power-down requests
  // ----------------------------------------------------------------
  // registered so the clock controller sees glitch-free levels; the
  // crystal only stops when the power/test register allows it
  // the enable freezes these requests as well, so a low clock enable holds
  // the last stop levels
  wire logic pdActive = ~powerDownInputN & ~loadPending_ff;
  wire logic pdXtal   = pdActive & powerTestReg[CFGIA_PTR_XTAL_BIT];

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      clocksStop_ff <= 1'b0;
      oscStop_ff    <= 1'b0;
    end else if (clkEn) begin
      clocksStop_ff <= pdActive;
      oscStop_ff    <= pdXtal;
    end
  end

  assign clocksStop = clocksStop_ff;
  assign oscStop    = oscStop_ff;

endmodule // cfgia_config_access

// ===== sim/cfgia_config_access_props.sv
// Concurrent checks on the ports of the configuration access unit.
// Assumes clkEn high except around one final index write; straps stable.
module cfgia_config_access_props (
  // clock and reset
  input wire logic         sys_clk,
  input wire logic         reset,
  // host bus
  input wire logic [15:0]  ioAddr,
  input wire logic         ioRdN,
  input wire logic         ioWrN,
  input wire logic [7:0]   ioDataIn,
  input wire logic [7:0]   ioDataOut,
  input wire logic         ioDataOe,
  // straps, power and registers
  input wire logic [1:0]   portLocationStraps,
  input wire logic         powerDownInputN,
  input wire logic         clocksStop,
  input wire logic         oscStop,
  input wire logic [7:0]   functionEnableReg,
  input wire logic [7:0]   functionAddressReg,
  input wire logic [7:0]   powerTestReg,
  input wire logic [119:0] cfgRegsFlat
);
  timeunit 1ns;
  timeprecision 1ns;
  import cfgia_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // --------------------------------------------------------------
  // shadow of strobe edges, arming and selected index
  // --------------------------------------------------------------
  logic       rdPrev_ff, wrPrev_ff, armed_ff;
  logic [3:0] idx_ff;
  logic [7:0] wData_ff;
  wire [15:0] baseAddr = CFGIA_INDEX_ADDR[portLocationStraps];
  wire        dataHit  = ioAddr == baseAddr + 16'h1;
  wire        hit      = dataHit || (ioAddr == baseAddr);
  wire        rdEdge   = !ioRdN && rdPrev_ff;
  wire        wrEdge   = !ioWrN && wrPrev_ff;
  wire [7:0]  selByte  = cfgRegsFlat[idx_ff*8 +: 8];
  // any foreign strobe also disarms, as the unit does
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      {rdPrev_ff, wrPrev_ff, armed_ff} <= 3'b110;
      idx_ff   <= 4'h0;
      wData_ff <= 8'h00;
    end else begin
      rdPrev_ff <= ioRdN;
      wrPrev_ff <= ioWrN;
      armed_ff  <= (wrEdge && dataHit) ? !armed_ff : (armed_ff && !wrEdge && !rdEdge);
      if (wrEdge && ioAddr == baseAddr) idx_ff <= ioDataIn[3:0];
      if (wrEdge) wData_ff <= ioDataIn;
    end
  end
  sequence sReadTaken; rdEdge && hit ##1 !ioRdN; endsequence
  sequence sCommit; wrEdge && dataHit && armed_ff && idx_ff != 4'hf; endsequence
  sequence sNoCommit; wrEdge && dataHit && (!armed_ff || idx_ff == 4'hf); endsequence
  a_oe_only_reading: assert property (ioDataOe |-> !ioRdN && hit)
    else $error("drive enable without a read of the port pair");
  a_oe_on_read: assert property (sReadTaken |-> ioDataOe)
    else $error("no drive during a port read");
  a_read_data_stands: assert property (!$past(rdEdge) |-> $stable(ioDataOut))
    else $error("read data moved without a read");
  a_first_write_holds: assert property (sNoCommit |=> $stable(cfgRegsFlat) [*2])
    else $error("register changed on an unpaired data write");
  a_second_write_commits: assert property (sCommit |-> ##[1:2] selByte == wData_ff)
    else $error("paired data write not committed");
  a_strap_regs_mirror: assert property (functionEnableReg == cfgRegsFlat[7:0] &&
    functionAddressReg == cfgRegsFlat[15:8] && powerTestReg == cfgRegsFlat[23:16])
    else $error("register outputs disagree with register file");
  a_clocks_stop: assert property (!powerDownInputN [*3] |-> clocksStop)
    else $error("clocks not stopped on power-down");
  a_clocks_run: assert property (powerDownInputN [*3] |-> !clocksStop && !oscStop)
    else $error("stop request without power-down");
  a_osc_stop: assert property ((!powerDownInputN && powerTestReg[1]) [*3] |-> oscStop)
    else $error("crystal not stopped");
  a_osc_needs_xtal: assert property (!powerTestReg[1] [*3] |-> !oscStop)
    else $error("crystal stopped without its enable");
endmodule // cfgia_config_access_props

bind cfgia_config_access cfgia_config_access_props i_cfgia_config_access_props (
  .sys_clk, .reset, .ioAddr, .ioRdN, .ioWrN, .ioDataIn, .ioDataOut, .ioDataOe,
  .portLocationStraps, .powerDownInputN, .clocksStop, .oscStop, .functionEnableReg,
  .functionAddressReg, .powerTestReg, .cfgRegsFlat);

// ===== sim/cfgia_host_model.sv
// Host processor model issuing configuration I/O cycles.
// Assumes the unit answers a read one cycle after the strobe is taken.
module cfgia_host_model (
  // clock
  input  wire logic                               sys_clk,
  // host bus
  output logic      [cfgia_pkg::CFGIA_ADDR_W-1:0] ioAddr,
  output logic                                    ioRdN,
  output logic                                    ioWrN,
  output logic      [cfgia_pkg::CFGIA_DATA_W-1:0] ioDataIn,
  input  wire logic [cfgia_pkg::CFGIA_DATA_W-1:0] ioDataOut,
  input  wire logic                               ioDataOe
);
  timeunit 1ns;
  timeprecision 1ns;
  import cfgia_pkg::*;
  // --------------------------------------------------------------
  // one strobe held low for two cycles; calls never interleave, so a
  // sequence runs as if interrupts were masked
  // --------------------------------------------------------------
  initial begin
    ioAddr   = 16'h0000;
    ioRdN    = 1'b1;
    ioWrN    = 1'b1;
    ioDataIn = 8'h00;
  end
  // index first, then paired data writes, is left to the caller
  task automatic ioCycle(input logic wr, input logic [15:0] a, input logic [7:0] d,
                         output logic [7:0] q, output logic oe);
    @(posedge sys_clk);
    ioAddr   <= a;
    ioDataIn <= d;
    if (wr) ioWrN <= 1'b0;
    else ioRdN <= 1'b0;
    repeat (2) @(posedge sys_clk);
    oe = ioDataOe;
    q  = ioDataOe ? ioDataOut : ~ioDataOut; // undriven bus shows no stale byte
    ioRdN    <= 1'b1;
    ioWrN    <= 1'b1;
    ioDataIn <= ~d;
  endtask
endmodule // cfgia_host_model

// ===== sim/testbench.sv
// Self-checking bench for the configuration access unit.
// Assumes the host model and the bound checker are compiled alongside.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import cfgia_pkg::*;
  logic         sys_clk, reset, powerDownInputN, oe, clkEn;
  logic [4:0]   defaultSelectStraps;
  logic [1:0]   portLocationStraps;
  logic [7:0]   q;
  logic [15:0]  b;
  wire  [15:0]  ioAddr;
  wire          ioRdN, ioWrN, ioDataOe, clocksStop, oscStop;
  wire  [7:0]   ioDataIn, ioDataOut, functionEnableReg, functionAddressReg, powerTestReg;
  wire  [119:0] cfgRegsFlat;
  int           nErrors, checkCount;
  localparam logic [15:0] LOC_ADDR [4] = '{16'h0398, 16'h026e, 16'h015c, 16'h002e};
  // expected address defaults, one row per strap code
  localparam logic [7:0] FAR_EXP [32] = '{8'h10, 8'h11, 8'h11, 8'h39, 8'h24, 8'h38,
    8'h00, 8'h01, 8'h01, 8'h09, 8'h08, 8'h08, 8'h10, 8'h11, 8'h39, 8'h24, 8'h00, 8'h01,
    8'h01, 8'h00, 8'h10, 8'h11, 8'h39, 8'h24, 8'h10, 8'h11, 8'h11, 8'h39, 8'h24, 8'h38,
    8'h10, 8'h10};
  cfgia_config_access i_cfgia_config_access (.sys_clk, .reset, .clkEn, .ioAddr,
    .ioRdN, .ioWrN, .ioDataIn, .ioDataOut, .ioDataOe, .defaultSelectStraps,
    .portLocationStraps, .powerDownInputN, .clocksStop, .oscStop, .functionEnableReg,
    .functionAddressReg, .powerTestReg, .cfgRegsFlat);
  cfgia_host_model i_cfgia_host_model (.sys_clk, .ioAddr, .ioRdN, .ioWrN, .ioDataIn,
    .ioDataOut, .ioDataOe);
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  function automatic logic [7:0] ferExp(input int c);
    logic [7:0] v;
    v = (c < 6) ? 8'h4f : (c < 12) ? 8'h4b : (c < 16) ? 8'h0f : (c < 20) ? 8'h49 :
        (c < 24) ? 8'h07 : (c < 30) ? 8'h47 : (c == 30) ? 8'h08 : 8'h00;
    if (c inside {2, 5, 8, 11, 18, 19, 26, 29}) v = v | 8'h80; // secondary disk address
    return v;
  endfunction
  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
    checkCount++;
    if (got !== exp) begin
      nErrors++;
      $display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chkBit(input logic got, input logic exp);
    checkCount++;
    if (got !== exp) begin
      nErrors++;
      $display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    i_cfgia_host_model.ioCycle(1'b1, a, d, q, oe);
  endtask
  task automatic wr2(input logic [15:0] a, input logic [7:0] d);
    wr(a, d);
    wr(a, d);
  endtask
  task automatic rdChk(input logic [15:0] a, input logic [7:0] exp);
    i_cfgia_host_model.ioCycle(1'b0, a, 8'h00, q, oe);
    chkByte(q, exp);
  endtask
  task automatic doReset(input int c);
    @(posedge sys_clk);
    reset               <= 1'b1;
    defaultSelectStraps <= c[4:0];
    portLocationStraps  <= c[1:0];
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic results;
    if (nErrors == 0 && checkCount > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog well beyond the expected run of under two thousand cycles
  initial begin
    #500us;
    nErrors++;
    results();
  end
  // --------------------------------------------------------------
  // main sequence: strap rows, then hand-written cases
  // --------------------------------------------------------------
  initial begin
    reset = 1'b1;
    powerDownInputN = 1'b1;
    clkEn = 1'b1;
    defaultSelectStraps = 5'h00;
    portLocationStraps = 2'h0;
    for (int i = 0; i < 32; i++) begin
      doReset(i);
      b = LOC_ADDR[i%4];
      chkByte(functionEnableReg, ferExp(i));
      chkByte(functionAddressReg, FAR_EXP[i]);
      chkByte(powerTestReg, (i == 31) ? 8'h02 : 8'h00);
      chkBit(cfgRegsFlat[119:24] === 96'h0, 1'b1);
      rdChk(b, CFGIA_ID_BYTE);
      rdChk(b, 8'h00);
      wr(b, 8'h01);
      rdChk(b + 16'h1, FAR_EXP[i]);
    end
    doReset(0);
    b = 16'h0398;
    wr(b, 8'hf3);
    rdChk(b, 8'h83);
    wr(b + 16'h1, 8'ha5);
    rdChk(b + 16'h1, 8'h00);
    wr(b + 16'h1, 8'h11);
    wr(b, 8'h03);
    wr(b + 16'h1, 8'h22);
    rdChk(b + 16'h1, 8'h00);
    wr2(b + 16'h1, 8'h33);
    rdChk(b + 16'h1, 8'h33);
    wr(b, 8'h00);
    wr2(b + 16'h1, 8'h5c);
    chkByte(functionEnableReg, 8'h5c);
    wr(b, 8'h0f);
    wr2(b + 16'h1, 8'h77);
    rdChk(b + 16'h1, 8'h00);
    chkBit(cfgRegsFlat === {88'h0, 8'h33, 8'h00, 8'h10, 8'h5c}, 1'b1);
    i_cfgia_host_model.ioCycle(1'b0, 16'h026e, 8'h00, q, oe);
    chkBit(oe, 1'b0);
    wr(b, 8'h02);
    wr2(b + 16'h1, 8'h02);
    powerDownInputN <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chkBit(clocksStop, 1'b1);
    chkBit(oscStop, 1'b1);
    wr2(b + 16'h1, 8'h00);
    repeat (4) @(posedge sys_clk);
    chkBit(oscStop, 1'b0);
    powerDownInputN <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chkBit(clocksStop, 1'b0);
    // an index write while the enable is low must leave the index alone
    clkEn <= 1'b0;
    wr(b, 8'h05);
    clkEn <= 1'b1;
    rdChk(b, 8'h02);
    results();
  end
endmodule // testbench
